// *** design/ptsl_port_block.sv ***
// Port latch, read path, pin output and touch select logic of one port
`timescale 1ns/1ps
`default_nettype none
`include "ptsl_defs.svh"
module ptsl_port_block
   import ptsl_pkg::*;
#(
   parameter int                  PORT_W     = 8,
   // Implemented touch select bits; 15'h0019 for the smallest variant
   parameter logic [14:0]         TOUCH_MASK = `PTSL_TS_MASK_FULL,
   // Touch select index for each pin, 4'hf where the pin has none
   parameter logic [PORT_W*4-1:0] TOUCH_IDX  = {PORT_W{4'hf}},
   parameter logic [PORT_W-1:0]   HAS_SERIAL = {PORT_W{1'b1}},
   parameter logic [PORT_W-1:0]   HAS_OTHER  = {PORT_W{1'b1}},
   parameter logic [PORT_W-1:0]   HAS_POM    = {PORT_W{1'b1}},
   // Pin that doubles as the touch capacitor pin
   parameter int                  CAP_PIN    = 2
) (
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   input  wire ptsl_bus_req_t       bus_req,
   output logic [7:0]               bus_rdata,
   input  wire logic [PORT_W-1:0]   pin_in,
   output logic [PORT_W-1:0]        pin_out,
   output logic [PORT_W-1:0]        pin_oe_n,
   output logic [PORT_W-1:0]        pin_din_en,
   input  wire logic [PORT_W-1:0]   serial_out,
   input  wire logic [PORT_W-1:0]   other_out,
   output logic [14:0]              touch_route,
   output logic                     cap_pin_input_gate
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0]        latch_reg;
   logic [7:0]        mode_reg;
   logic [7:0]        analog_reg;
   logic [7:0]        od_reg;
   logic [14:0]       touch_select_reg;
   logic [7:0]        cap_pin_config_reg;
   logic [7:0]        rdata_next;
   logic [7:0]        pin_sample_reg;
   logic [7:0]        port_view;
   logic [7:0]        latch_next;
   logic [14:0]       touch_next;
   logic [7:0]        cap_next;
   logic [PORT_W-1:0] pin_touch;
   logic              touch_active;
   ptsl_pin_drv_t     drv [PORT_W];

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Apply a byte write or a single bit manipulation to an old value
   function automatic logic [7:0] ptsl_merge(input logic [7:0] old_val,
                                             input ptsl_bus_req_t req);
      logic [7:0] res;
      res = old_val;
      if (req.bit_op) begin
         res[req.bit_sel] = req.bit_val;
      end else begin
         res = req.wdata;
      end
      return res;
   endfunction : ptsl_merge

   // Address match for a write to one register
   // Kept as a function so every write decoder compares the full address
   function automatic logic ptsl_hit(input ptsl_bus_req_t req,
                                     input logic [19:0] addr);
      return req.addr == addr;
   endfunction : ptsl_hit

   // Look up the touch select bit that owns one pin
   // An index of all ones marks a pin with no touch function
   function automatic logic ptsl_touch_of(input logic [14:0] sel,
                                          input logic [3:0] idx);
      logic res;
      res = 1'b0;
      if (idx != `PTSL_TOUCH_NONE) begin
         res = sel[idx];
      end
      return res;
   endfunction : ptsl_touch_of

   // ----------------------------------------------------------------
   // Pin sampling and port view
   // ----------------------------------------------------------------

   // Pins are taken as synchronous; one stage gives a stable read value
   // Limitation: a pin change reaches a read two cycles later
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_sample_reg <= 8'h00;
      end else begin
         pin_sample_reg <= 8'(pin_in);
      end
   end

   // Per bit: input mode shows the pin, output mode shows the latch.
   // Analog pins in input mode have the digital input buffer off and read low.
   // Bit positions beyond the port width read as zero.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (i >= PORT_W) begin
            port_view[i] = 1'b0;
         end else if (mode_reg[i]) begin
            port_view[i] = pin_sample_reg[i] & ~analog_reg[i];
         end else begin
            port_view[i] = latch_reg[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Output latch
   // ----------------------------------------------------------------

   // A byte write stores the data whatever the mode. A bit manipulation
   // is a read-modify-write whose operand is the port view, so in input
   // mode the pin level of the other bits lands in the latch.
   // Load the latch before turning a pin to output to avoid a glitch.
   always_comb begin
      latch_next = latch_reg;
      if (bus_req.wr && ptsl_hit(bus_req, `PTSL_LATCH_ADDR)) begin
         latch_next = ptsl_merge(port_view, bus_req);
      end
   end

   // Latch only changes on a write; reads leave it alone
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_reg <= `PTSL_LATCH_RESET;
      end else begin
         latch_reg <= latch_next;
      end
   end

   // ----------------------------------------------------------------
   // Port mode, analog select and open-drain registers
   // ----------------------------------------------------------------

   // Mode register: 1 selects input, so pins start with buffers off
   // and no pad is driven until software has set up its latch
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= `PTSL_MODE_RESET;
      end else if (bus_req.wr && ptsl_hit(bus_req, `PTSL_MODE_ADDR)) begin
         mode_reg <= ptsl_merge(mode_reg, bus_req);
      end
   end

   // Analog select: 1 gives the pin to the analog input
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         analog_reg <= `PTSL_ANALOG_RESET;
      end else if (bus_req.wr && ptsl_hit(bus_req, `PTSL_ANALOG_ADDR)) begin
         analog_reg <= ptsl_merge(analog_reg, bus_req);
      end
   end

   // Open-drain select; bits for pins without one are never stored
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         od_reg <= `PTSL_OD_RESET;
      end else if (bus_req.wr && ptsl_hit(bus_req, `PTSL_OD_ADDR)) begin
         od_reg <= ptsl_merge(od_reg, bus_req) & 8'(HAS_POM);
      end
   end

   // ----------------------------------------------------------------
   // Touch select registers
   // ----------------------------------------------------------------

   // Both halves take bit or byte writes; unbuilt bits stay zero
   // The high half has no bit 7, so a write to it is dropped
   always_comb begin
      touch_next = touch_select_reg;
      if (bus_req.wr && ptsl_hit(bus_req, `PTSL_TS_LOW_ADDR)) begin
         touch_next[7:0] = ptsl_merge(touch_select_reg[7:0], bus_req);
      end
      if (bus_req.wr && ptsl_hit(bus_req, `PTSL_TS_HIGH_ADDR)) begin
         touch_next[14:8] = 7'(ptsl_merge({1'b0, touch_select_reg[14:8]},
                                          bus_req));
      end
      touch_next = touch_next & TOUCH_MASK;
   end

   // Reset leaves every pin on its ordinary function
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         touch_select_reg <= `PTSL_TS_RESET;
      end else begin
         touch_select_reg <= touch_next;
      end
   end

   // ----------------------------------------------------------------
   // Capacitor pin configuration
   // ----------------------------------------------------------------

   // Byte writes only: a bit manipulation here is dropped, since the
   // register has no single-bit access path
   // Upper bits are kept zero so a read shows only the gate bit
   always_comb begin
      cap_next = cap_pin_config_reg;
      if (bus_req.wr && !bus_req.bit_op &&
          ptsl_hit(bus_req, `PTSL_CAP_CFG_ADDR)) begin
         cap_next = bus_req.wdata & `PTSL_CAP_MASK;
      end
   end

   // Cleared at reset; with touch idle the capacitor input still starts open
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cap_pin_config_reg <= `PTSL_CAP_RESET;
      end else begin
         cap_pin_config_reg <= cap_next;
      end
   end

   // ----------------------------------------------------------------
   // Touch routing and capacitor gate outputs
   // ----------------------------------------------------------------

   // Any stored select bit hands the capacitor pin to touch sensing;
   // unbuilt bits are masked on write, so they never count here
   assign touch_active = |touch_select_reg;

   // Each set bit hands its pin to the touch-sense function
   // Taken from the next value so the route and the stored select bits
   // change on the same edge and software never sees them differ
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         touch_route <= `PTSL_TS_RESET;
      end else begin
         touch_route <= touch_next;
      end
   end

   // Config only matters while touch is in use; otherwise the
   // capacitor pin input keeps its ordinary path open
   // Next values keep the gate in step with the writing edge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cap_pin_input_gate <= `PTSL_CAP_GATE_OPEN;
      end else if (|touch_next) begin
         cap_pin_input_gate <= cap_next[`PTSL_CAP_GATE_BIT];
      end else begin
         cap_pin_input_gate <= `PTSL_CAP_GATE_OPEN;
      end
   end

   // ----------------------------------------------------------------
   // Pin output combining
   // ----------------------------------------------------------------

   // Touch ownership per pin, taken from the index table
   always_comb begin
      for (int i = 0; i < PORT_W; i++) begin
         pin_touch[i] = ptsl_touch_of(touch_select_reg, TOUCH_IDX[i*4 +: 4]);
      end
   end

   // One combining path per pin; the capacitor pin input is also shut
   // while touch is active and the gate bit is clear
   // Absent serial, other or open-drain sources are tied inside each path
   generate
      for (genvar g = 0; g < PORT_W; g++) begin : g_pin
         ptsl_pin_drive #(
            .HAS_SERIAL (HAS_SERIAL[g]),
            .HAS_OTHER  (HAS_OTHER[g]),
            .HAS_POM    (HAS_POM[g])
         ) u_drive (
            .latch_bit             (latch_reg[g]),
            .serial_out            (serial_out[g]),
            .other_out             (other_out[g]),
            .open_drain_select_bit (od_reg[g]),
            .is_input              (mode_reg[g]),
            .is_analog             (analog_reg[g]),
            .is_touch              (pin_touch[g]),
            .drv                   (drv[g])
         );
      end
   endgenerate

   // Registered pad drive so every output leaves a flip-flop; this adds
   // one cycle of latency from a latch write to the pin
   // The capacitor pin input follows the gate bit only while touch is on
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out    <= '0;
         pin_oe_n   <= '1;
         pin_din_en <= '0;
      end else begin
         for (int i = 0; i < PORT_W; i++) begin
            pin_out[i]  <= drv[i].val;
            pin_oe_n[i] <= drv[i].oe_n;
            if (i == CAP_PIN && touch_active) begin
               pin_din_en[i] <= cap_pin_config_reg[`PTSL_CAP_GATE_BIT];
            end else begin
               pin_din_en[i] <= drv[i].din_en;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------

   // Read data mux; unmapped addresses return zero
   // A read and a write to one register in one cycle return the old value
   always_comb begin
      rdata_next = 8'h00;
      if (bus_req.rd) begin
         case (bus_req.addr)
            `PTSL_LATCH_ADDR:   rdata_next = port_view;
            `PTSL_MODE_ADDR:    rdata_next = mode_reg;
            `PTSL_ANALOG_ADDR:  rdata_next = analog_reg;
            `PTSL_OD_ADDR:      rdata_next = od_reg;
            `PTSL_TS_LOW_ADDR:  rdata_next = touch_select_reg[7:0];
            `PTSL_TS_HIGH_ADDR: rdata_next = {1'b0, touch_select_reg[14:8]};
            `PTSL_CAP_CFG_ADDR: rdata_next = cap_pin_config_reg;
            default:            rdata_next = 8'h00;
         endcase
      end
   end

   // Read data returns one cycle after the request and holds
   // Holding between reads lets a slow consumer still pick the value up
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_req.rd) begin
         bus_rdata <= rdata_next;
      end
   end

endmodule : ptsl_port_block
`default_nettype wire

// *** design/ptsl_defs.svh ***
// Constants for the port pin and touch select logic
`ifndef PTSL_DEFS_SVH
`define PTSL_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PTSL_ADDR_W         20
`define PTSL_TS_LOW_ADDR    20'hf030a
`define PTSL_TS_HIGH_ADDR   20'hf030b
`define PTSL_CAP_CFG_ADDR   20'hf030d
`define PTSL_LATCH_ADDR     20'hfff00
`define PTSL_MODE_ADDR      20'hfff20
`define PTSL_ANALOG_ADDR    20'hf0060
`define PTSL_OD_ADDR        20'hf0050

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define PTSL_TS_RESET       15'h0000
`define PTSL_CAP_RESET      8'h00
`define PTSL_LATCH_RESET    8'h00
`define PTSL_MODE_RESET     8'hff
`define PTSL_ANALOG_RESET   8'h00
`define PTSL_OD_RESET       8'h00
`define PTSL_CAP_MASK       8'h01
`define PTSL_CAP_GATE_BIT   0
`define PTSL_CAP_GATE_OPEN  1'b1
`define PTSL_TS_LOW_W       8
`define PTSL_TS_W           15
`define PTSL_TOUCH_NONE     4'hf
`define PTSL_TS_MASK_FULL   15'h7fff
`define PTSL_TS_MASK_10PIN  15'h0019

`endif

// *** design/ptsl_pkg.sv ***
// Types shared by the port pin and touch select logic
package ptsl_pkg;

   // CPU memory bus request; bit_op marks a one-bit manipulation
   typedef struct packed {
      logic [19:0] addr;
      logic        wr;
      logic        rd;
      logic        bit_op;
      logic [2:0]  bit_sel;
      logic        bit_val;
      logic [7:0]  wdata;
   } ptsl_bus_req_t;

   // Output drive toward one pin pad
   typedef struct packed {
      logic val;
      logic oe_n;
      logic din_en;
   } ptsl_pin_drv_t;

endpackage : ptsl_pkg

// *** design/ptsl_pin_drive.sv ***
// Output combining path of one digital pin
`timescale 1ns/1ps
`default_nettype none
module ptsl_pin_drive
   import ptsl_pkg::*;
#(
   parameter bit HAS_SERIAL = 1'b1,
   parameter bit HAS_OTHER  = 1'b1,
   parameter bit HAS_POM    = 1'b1
) (
   input  wire logic    latch_bit,
   input  wire logic    serial_out,
   input  wire logic    other_out,
   input  wire logic    open_drain_select_bit,
   input  wire logic    is_input,
   input  wire logic    is_analog,
   input  wire logic    is_touch,
   output ptsl_pin_drv_t drv
);

   logic serial_term;
   logic other_term;
   logic od_term;
   logic level;

   // Absent sources are tied so they cannot disturb the others
   assign serial_term = HAS_SERIAL ? serial_out : 1'b1;
   assign other_term  = HAS_OTHER  ? other_out  : 1'b0;
   assign od_term     = HAS_POM    ? open_drain_select_bit : 1'b0;

   // Latch AND serial, then OR with the other alternate outputs
   assign level = (latch_bit & serial_term) | other_term;

   // Buffer off in input, analog or touch use; open drain only pulls low
   always_comb begin
      drv.val    = level;
      drv.oe_n   = is_input | is_analog | is_touch | (od_term & level);
      drv.din_en = ~is_analog & ~is_touch;
   end

endmodule : ptsl_pin_drive
`default_nettype wire

// *** verif/ptsl_port_props.sv ***
// Concurrent checks on the port pin and touch select block
`timescale 1ns/1ps
`default_nettype none
`include "ptsl_defs.svh"
module ptsl_port_props
   import ptsl_pkg::*;
#(
   parameter int          PORT_W     = 8,
   parameter logic [14:0] TOUCH_MASK = 15'h7fff,
   parameter int          CAP_PIN    = 2
) (
   input wire logic                core_clk,
   input wire logic                reset_n,
   input wire ptsl_bus_req_t       bus_req,
   input wire logic [7:0]          bus_rdata,
   input wire logic [PORT_W-1:0]   pin_in,
   input wire logic [PORT_W-1:0]   pin_out,
   input wire logic [PORT_W-1:0]   pin_oe_n,
   input wire logic [PORT_W-1:0]   pin_din_en,
   input wire logic [PORT_W-1:0]   serial_out,
   input wire logic [PORT_W-1:0]   other_out,
   input wire logic [14:0]         touch_route,
   input wire logic                cap_pin_input_gate
);
   // One clock domain, so clock and reset are given once
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   reset_state_a : assert property ($rose(reset_n) |-> touch_route == 15'h0000
      && cap_pin_input_gate && bus_rdata == 8'h00) else $error("state after reset wrong");
   route_mask_a : assert property ((touch_route & ~TOUCH_MASK) == 15'h0000)
      else $error("unimplemented touch bit set");
   ts_byte_write_a : assert property (bus_req.wr && !bus_req.bit_op
      && bus_req.addr == `PTSL_TS_LOW_ADDR
      |=> touch_route[7:0] == ($past(bus_req.wdata) & TOUCH_MASK[7:0]))
      else $error("touch byte write not taken");
   no_write_hold_a : assert property (!bus_req.wr |=> $stable(touch_route)
      && $stable(cap_pin_input_gate)) else $error("select changed without write");
   cap_bitop_a : assert property (bus_req.wr && bus_req.bit_op
      && bus_req.addr == `PTSL_CAP_CFG_ADDR |=> $stable(cap_pin_input_gate))
      else $error("bit write changed cap config");
   cap_idle_a : assert property (touch_route == 15'h0000 |-> cap_pin_input_gate)
      else $error("cap gate acts with touch idle");
   cap_din_a : assert property (touch_route != 15'h0000 && $past(touch_route) != 15'h0000
      && $stable(cap_pin_input_gate) |-> pin_din_en[CAP_PIN] == cap_pin_input_gate)
      else $error("cap pin input not gated");
   touch_owns_a : assert property (touch_route[0] && $past(touch_route[0])
      |-> pin_oe_n[0]) else $error("touch pin still driven");
   or_path_a : assert property ($past(reset_n) && $past(other_out[1]) |-> pin_out[1])
      else $error("other output not merged");
   and_path_a : assert property ($past(reset_n) && !$past(serial_out[1])
      && !$past(other_out[1]) |-> !pin_out[1]) else $error("serial output not merged");
endmodule : ptsl_port_props

bind ptsl_port_block ptsl_port_props #(
   .PORT_W(PORT_W), .TOUCH_MASK(TOUCH_MASK), .CAP_PIN(CAP_PIN)
) u_props (
   .core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_din_en(pin_din_en),
   .serial_out(serial_out), .other_out(other_out), .touch_route(touch_route),
   .cap_pin_input_gate(cap_pin_input_gate)
);
`default_nettype wire

// *** verif/ptsl_pin_world.sv ***
// Pad model: what the outside world presents on the port pins
`timescale 1ns/1ps
`default_nettype none
module ptsl_pin_world #(
   parameter int PORT_W = 8
) (
   input  wire logic [PORT_W-1:0] pin_out,
   input  wire logic [PORT_W-1:0] pin_oe_n,
   input  wire logic [PORT_W-1:0] ext_level,
   output logic [PORT_W-1:0]      pin_in
);
   // Own drive wins while enabled; a released pad shows the outside level
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : ptsl_pin_world
`default_nettype wire

// *** verif/ptsl_port_block_bench.sv ***
// Self-checking bench for the port pin and touch select block
`timescale 1ns/1ps
`default_nettype none
`include "ptsl_defs.svh"
module ptsl_port_block_bench;
   import ptsl_pkg::*;
   localparam logic [19:0] A_LOW = `PTSL_TS_LOW_ADDR;
   localparam logic [19:0] A_HI  = `PTSL_TS_HIGH_ADDR;
   localparam logic [19:0] A_CAP = `PTSL_CAP_CFG_ADDR;
   localparam logic [19:0] A_LAT = `PTSL_LATCH_ADDR;
   localparam logic [19:0] A_MOD = `PTSL_MODE_ADDR;
   localparam logic [19:0] A_ANA = `PTSL_ANALOG_ADDR;
   localparam logic [19:0] A_OD  = `PTSL_OD_ADDR;
   localparam logic [7:0]  SER   = 8'h7f;
   localparam logic [7:0]  OTH   = 8'hbf;
   localparam logic [7:0]  OUTPUT_MODE_REGISTER   = 8'hdf;
   logic          core_clk = 1'b0;
   logic          reset_n;
   ptsl_bus_req_t bus_req;
   logic [7:0]    bus_rdata, pin_in, pin_out, pin_oe_n, pin_din_en;
   logic [7:0]    serial_out, other_out, ext_level;
   logic [14:0]   touch_route;
   logic          cap_pin_input_gate;
   int            bad_count = 0;
   int            cmp_count = 0;

   // 250 MHz core clock
   always #2 core_clk = ~core_clk;

   ptsl_port_block #(.PORT_W(8), .TOUCH_MASK(`PTSL_TS_MASK_10PIN),
      .TOUCH_IDX({28'hfffffff, 4'h0}), .HAS_SERIAL(SER), .HAS_OTHER(OTH),
      .HAS_POM(OUTPUT_MODE_REGISTER), .CAP_PIN(2)) dut (
      .core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_din_en(pin_din_en),
      .serial_out(serial_out), .other_out(other_out), .touch_route(touch_route),
      .cap_pin_input_gate(cap_pin_input_gate));
   ptsl_pin_world #(.PORT_W(8)) world (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_level(ext_level), .pin_in(pin_in));

   // ------------------------------------------------------------
   // Bus cycles and comparison
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One request, held for exactly one taking edge
   task automatic bus(input logic [19:0] a, input logic w, input logic b,
                      input logic [2:0] s, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wr: w, rd: !w, bit_op: b, bit_sel: s, bit_val: d[0], wdata: d};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
   endtask : bus
   task automatic wb(input logic [19:0] a, input logic [7:0] d);
      bus(a, 1'b1, 1'b0, 3'd0, d);
   endtask : wb
   task automatic wbit(input logic [19:0] a, input logic [2:0] s, input logic v);
      bus(a, 1'b1, 1'b1, s, {7'h00, v});
   endtask : wbit
   task automatic rdc(input logic [19:0] a, input logic [7:0] e);
      bus(a, 1'b0, 1'b0, 3'd0, 8'h00);
      chk(16'(bus_rdata), 16'(e));
   endtask : rdc
   // Pads lag registers by a cycle, sampled pins by one more
   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic drv(input logic [7:0] s, input logic [7:0] o, input logic [7:0] e);
      @(posedge core_clk);
      serial_out <= s;
      other_out  <= o;
      ext_level  <= e;
   endtask : drv

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk(16'(touch_route), 16'h0000);
      chk(16'(cap_pin_input_gate), 16'h0001);
      rdc(A_LOW, 8'h00);
      rdc(A_HI, 8'h00);
      rdc(A_CAP, 8'h00);
      rdc(A_ANA, 8'h00);
      wb(A_MOD, 8'h00);
      rdc(A_LAT, 8'h00);
   endtask : t_reset
   task automatic t_touch;
      wb(A_LOW, 8'hff);
      rdc(A_LOW, 8'h19);
      wb(A_HI, 8'hff);
      rdc(A_HI, 8'h00);
      wb(A_LOW, 8'h00);
      wbit(A_LOW, 3'd3, 1'b1);
      wbit(A_LOW, 3'd4, 1'b1);
      wbit(A_LOW, 3'd4, 1'b0);
      chk(16'(touch_route), 16'h0008);
      wb(A_LAT, 8'h01);
      wbit(A_LOW, 3'd0, 1'b1);
      settle;
      chk(16'(pin_oe_n[0]), 16'h0001);
      wb(A_LOW, 8'h00);
      settle;
      chk(16'({pin_oe_n[0], pin_out[0]}), 16'h0001);
   endtask : t_touch
   task automatic t_cap;
      wb(A_CAP, 8'h00);
      chk(16'(cap_pin_input_gate), 16'h0001);
      wbit(A_LOW, 3'd0, 1'b1);
      chk(16'(cap_pin_input_gate), 16'h0000);
      wbit(A_CAP, 3'd0, 1'b1);
      chk(16'(cap_pin_input_gate), 16'h0000);
      wb(A_CAP, 8'hff);
      rdc(A_CAP, 8'h01);
      settle;
      chk(16'({pin_din_en[2], cap_pin_input_gate}), 16'h0003);
      wb(A_CAP, 8'h00);
      settle;
      chk(16'(pin_din_en[2]), 16'h0000);
      wb(A_LOW, 8'h00);
      chk(16'(cap_pin_input_gate), 16'h0001);
   endtask : t_cap
   task automatic t_output;
      drv(8'hff, 8'h00, 8'h5a);
      wb(A_MOD, 8'h00);
      wb(A_LAT, 8'ha5);
      settle;
      chk({pin_oe_n, pin_out}, 16'h00a5);
      rdc(A_LAT, 8'ha5);
      rdc(A_LAT, 8'ha5);
      wbit(A_LAT, 3'd1, 1'b1);
      settle;
      chk(16'(pin_out), 16'h00a7);
   endtask : t_output
   task automatic t_input;
      drv(8'hff, 8'h00, 8'h3c);
      wb(A_MOD, 8'hff);
      wb(A_LAT, 8'h0f);
      settle;
      chk(16'(pin_oe_n), 16'h00ff);
      rdc(A_LAT, 8'h3c);
      wb(A_MOD, 8'h00);
      rdc(A_LAT, 8'h0f);
      wb(A_MOD, 8'hff);
      settle;
      wbit(A_LAT, 3'd0, 1'b1);
      wb(A_MOD, 8'h00);
      rdc(A_LAT, 8'h3d);
   endtask : t_input
   task automatic t_combine;
      wb(A_LAT, 8'hff);
      drv(8'h0d, 8'h70, 8'h00);
      settle;
      chk(16'(pin_out), 16'((8'hff & (8'h0d | ~SER)) | (8'h70 & OTH)));
      wb(A_OD, 8'hff);
      settle;
      chk(16'(pin_oe_n), 16'((8'h0d | ~SER | (8'h70 & OTH)) & OUTPUT_MODE_REGISTER));
      wb(A_OD, 8'h00);
      wb(A_LAT, 8'h00);
      drv(8'hff, 8'h82, 8'h00);
      settle;
      chk(16'(pin_out), 16'h0082);
   endtask : t_combine
   task automatic t_analog;
      drv(8'hff, 8'h00, 8'h08);
      wb(A_MOD, 8'hff);
      wb(A_ANA, 8'h08);
      settle;
      rdc(A_LAT, 8'h00);
      chk(16'(pin_din_en[3]), 16'h0000);
      wb(A_ANA, 8'h00);
      settle;
      rdc(A_LAT, 8'h08);
   endtask : t_analog

   // ------------------------------------------------------------
   // Verdict, main sequence and watchdog
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      reset_n    = 1'b0;
      bus_req    = '0;
      serial_out = 8'hff;
      other_out  = 8'h00;
      ext_level  = 8'h00;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      t_reset;
      t_touch;
      t_cap;
      t_output;
      t_input;
      t_combine;
      t_analog;
      tally_and_finish;
   end
   // About fifty bus cycles are expected; far beyond that is a hang
   initial begin
      #40000;
      bad_count++;
      tally_and_finish;
   end
endmodule : ptsl_port_block_bench
`default_nettype wire
